// file: hdl/brc_pkg.sv
// Constants, types and helpers of the burst read configuration sequencer
//
// Contract
// - Order field 0 gives interleaved addresses, 1 gives sequential.
// - Edge field 0 makes falling clock edge active, 1 rising.
// - Wrap field 0 wraps inside aligned block, 1 runs past it; the code keeps fixed-length interleaved bursts in the block either way.
// - Length codes 001/010/011/111 give 4, 8, 16 words, continuous.
// - Continuous bursts keep incrementing across bank boundaries.
// - Wrapped sequential bursts step modulo length inside the block.
// - Interleaved order is start index XOR a rising count.
// - Aligned no-wrap or continuous starts insert no wait states.
// - Start offset 1..3 adds that many waits at first 16-word crossing.
// - Continuous bursts insert boundary waits only once.
// - Read mode 0 is synchronous, 1 asynchronous, 1 after reset.
// - Wait polarity 0 drives wait active low, 1 active high.
// - Hold field 0 keeps each word one clock, 1 two clocks.
// - Wait timing 0 flags wait state itself, 1 one data cycle early.
// - Latency counts clocks from address latch to first data word.
// - Burst starts on first active edge after select goes low.
// - Data is invalid while wait is asserted with wait timing 0.
package brc_pkg;

    // ------------------------------------------------------------------
    // Widths and register constants
    // ------------------------------------------------------------------
    localparam int          BRC_ADDR_W    = 21;
    localparam int          BRC_DATA_W    = 16;
    localparam logic [15:0] CFG_RESET     = 16'hBFCF;
    localparam logic [15:0] CFG_RSVD_MASK = 16'h4030;

    // Burst length codes
    localparam logic [2:0]  LEN_4         = 3'h1;
    localparam logic [2:0]  LEN_8         = 3'h2;
    localparam logic [2:0]  LEN_16        = 3'h3;
    localparam logic [2:0]  LEN_CONT      = 3'h7;

    // Latency codes and the fallback for reserved codes
    localparam logic [2:0]  LAT_2         = 3'h2;
    localparam logic [2:0]  LAT_3         = 3'h3;
    localparam logic [2:0]  LAT_4         = 3'h4;
    localparam logic [2:0]  LAT_5         = 3'h5;
    localparam logic [2:0]  LAT_FALLBACK  = 3'h5;

    // Last word index of a 16-word array boundary
    localparam logic [3:0]  BND_LAST      = 4'hF;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       read_mode;
        logic       rsvd_hi;
        logic [2:0] latency;
        logic       wait_pol;
        logic       data_hold;
        logic       wait_timing;
        logic       burst_order;
        logic       edge_sel;
        logic [1:0] rsvd_lo;
        logic       wrap_sel;
        logic [2:0] burst_length;
    } brc_cfg_t;

    typedef enum logic [2:0] {
        SLOT_END  = 3'h1,
        SLOT_WAIT = 3'h2,
        SLOT_DATA = 3'h4
    } brc_slot_kind_t;

    typedef struct packed {
        brc_slot_kind_t          kind;
        logic [BRC_ADDR_W-1:0]   addr;
    } brc_slot_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ARMED  = 4'h2,
        ST_LAT    = 4'h4,
        ST_STREAM = 4'h8
    } brc_state_t;

    // ------------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------------
    // Words per burst; zero means continuous (reserved codes too)
    function automatic logic [4:0] burst_words(input logic [2:0] code);
        unique case (code)
            LEN_4:   burst_words = 5'h04;
            LEN_8:   burst_words = 5'h08;
            LEN_16:  burst_words = 5'h10;
            default: burst_words = 5'h00;
        endcase
    endfunction : burst_words

    function automatic logic [2:0] lat_clocks(input logic [2:0] code);
        unique case (code)
            LAT_2, LAT_3, LAT_4, LAT_5: lat_clocks = code;
            default:                    lat_clocks = LAT_FALLBACK;
        endcase
    endfunction : lat_clocks

endpackage : brc_pkg

// file: hdl/brc_addr_gen.sv
// Word address order generator for one burst index
`timescale 1ns/10ps
`default_nettype none
module brc_addr_gen
    import brc_pkg::*;
#(
    parameter int ADDR_W = BRC_ADDR_W
)
(
    input  wire logic [ADDR_W-1:0] start_addr,
    input  wire logic [ADDR_W-1:0] word_idx,
    input  wire brc_cfg_t          cfg,
    output logic      [ADDR_W-1:0] word_addr
);

    // ------------------------------------------------------------------
    // Block mask and address order
    // ------------------------------------------------------------------
    logic [4:0]        words;
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] lin;

    assign words = burst_words(cfg.burst_length);
    assign mask  = {{(ADDR_W-5){1'b0}}, words - 5'h01};
    assign lin   = start_addr + word_idx;

    // Continuous ignores wrap and order; a fixed-length interleaved burst stays in its block
    always_comb
    begin
        if (words == 5'h00)
            word_addr = lin;
        else if (!cfg.burst_order)
            word_addr = (start_addr & ~mask)
                      | ((start_addr ^ word_idx) & mask);
        else if (!cfg.wrap_sel)
            word_addr = (start_addr & ~mask) | (lin & mask);
        else
            word_addr = lin;
    end

endmodule : brc_addr_gen
`default_nettype wire

// file: hdl/brc_sequencer.sv
// Burst read configuration register and synchronous burst sequencer
`timescale 1ns/10ps
`default_nettype none
module brc_sequencer
    import brc_pkg::*;
#(
    parameter int ADDR_W = BRC_ADDR_W,
    parameter int DATA_W = BRC_DATA_W
)
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              cfg_wr_en,
    input  wire logic [15:0]       cfg_wdata,
    output logic      [15:0]       cfg_rdata,
    input  wire logic              flash_clk,
    input  wire logic              latch_n,
    input  wire logic              chip_en_n,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] array_rdata,
    output logic      [ADDR_W-1:0] burst_addr,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    output logic                   data_valid,
    output logic                   wait_pin
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    brc_cfg_t          cfg_r;
    brc_state_t        st_r;
    brc_slot_t         cur_r;
    brc_slot_t         look_r;
    brc_slot_t         gen_slot;
    logic [ADDR_W-1:0] start_r;
    logic [ADDR_W-1:0] word_idx_r;
    logic [ADDR_W-1:0] gen_addr;
    logic [1:0]        wait_left_r;
    logic              waited_r;
    logic [2:0]        lat_cnt_r;
    logic              phase_r;
    logic              k_prev_r;
    logic              sel_prev_r;
    logic [15:0]       cfg_rdata_r;
    logic [ADDR_W-1:0] burst_addr_r;
    logic [DATA_W-1:0] dq_out_r;
    logic              dq_oe_r;
    logic              data_valid_r;
    logic              wait_pin_r;
    logic              sel;
    logic              sel_rise;
    logic              active_edge;
    logic              slot_load;
    logic              gen_step;
    logic              cont;
    logic [4:0]        words;
    logic              wait_eligible;
    logic              wait_int;

    assign cfg_rdata  = cfg_rdata_r;
    assign burst_addr = burst_addr_r;
    assign dq_out     = dq_out_r;
    assign dq_oe      = dq_oe_r;
    assign data_valid = data_valid_r;
    assign wait_pin   = wait_pin_r;

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // Reserved bits are never stored, so they always read back as zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cfg_r <= brc_cfg_t'(CFG_RESET);
        else if (clk_en && cfg_wr_en)
            cfg_r <= brc_cfg_t'(cfg_wdata & ~CFG_RSVD_MASK);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            cfg_rdata_r <= CFG_RESET;
        else if (clk_en)
            cfg_rdata_r <= cfg_r;
    end

    // ------------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------------
    // Pins are synchronous to sys_clk; the flash clock must run well
    // below half the system rate so that each of its edges is seen
    assign sel         = !latch_n && !chip_en_n;
    assign sel_rise    = sel && !sel_prev_r;
    assign active_edge = cfg_r.edge_sel ? (flash_clk && !k_prev_r)
                                        : (!flash_clk && k_prev_r);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            k_prev_r   <= 1'b0;
            sel_prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            k_prev_r   <= flash_clk;
            sel_prev_r <= sel;
        end
    end

    // ------------------------------------------------------------------
    // Slot generator
    // ------------------------------------------------------------------
    brc_addr_gen #(
        .ADDR_W     (ADDR_W)
    ) u_addr_gen (
        .start_addr (start_r),
        .word_idx   (word_idx_r),
        .cfg        (cfg_r),
        .word_addr  (gen_addr)
    );

    assign words = burst_words(cfg_r.burst_length);
    assign cont  = (words == 5'h00);
    // Only bursts that leave their block can meet an array boundary
    assign wait_eligible = cont || (cfg_r.wrap_sel && cfg_r.burst_order);

    // Next slot: pending waits first, then a word, then the end marker
    always_comb
    begin
        gen_slot.kind = SLOT_DATA;
        gen_slot.addr = gen_addr;
        if (wait_left_r != 2'h0)
        begin
            gen_slot.kind = SLOT_WAIT;
            gen_slot.addr = '0;
        end
        else if (!cont && word_idx_r == {{(ADDR_W-5){1'b0}}, words})
        begin
            gen_slot.kind = SLOT_END;
            gen_slot.addr = '0;
        end
    end

    // Generator state; a fresh latch restarts it from the new address
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            word_idx_r  <= '0;
            wait_left_r <= 2'h0;
            waited_r    <= 1'b0;
            start_r     <= '0;
        end
        else if (clk_en)
        begin
            if (sel_rise)
            begin
                start_r     <= addr_in;
                word_idx_r  <= '0;
                wait_left_r <= 2'h0;
                waited_r    <= 1'b0;
            end
            else if (gen_step)
            begin
                if (wait_left_r != 2'h0)
                    wait_left_r <= wait_left_r - 2'h1;
                else if (gen_slot.kind == SLOT_DATA)
                begin
                    word_idx_r <= word_idx_r + 1'b1;
                    // Crossing happens once; aligned starts add zero
                    if (wait_eligible && !waited_r &&
                        gen_addr[3:0] == BND_LAST &&
                        (cont || word_idx_r + 1'b1 <
                         {{(ADDR_W-5){1'b0}}, words}))
                    begin
                        wait_left_r <= start_r[1:0];
                        waited_r    <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Burst control
    // ------------------------------------------------------------------
    assign slot_load = active_edge &&
                       ((st_r == ST_LAT && lat_cnt_r == 3'h1) ||
                        (st_r == ST_STREAM &&
                         (phase_r || !cfg_r.data_hold)));
    assign gen_step  = (active_edge && st_r == ST_ARMED) || slot_load;

    // Chip select release aborts; a new latch restarts at any time
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_r      <= ST_IDLE;
            lat_cnt_r <= 3'h0;
        end
        else if (clk_en)
        begin
            if (chip_en_n)
                st_r <= ST_IDLE;
            else if (sel_rise)
                st_r <= cfg_r.read_mode ? ST_IDLE : ST_ARMED;
            else
            begin
                unique case (st_r)
                    ST_IDLE:   st_r <= ST_IDLE;
                    ST_ARMED:
                        if (active_edge)
                        begin
                            st_r      <= ST_LAT;
                            lat_cnt_r <= lat_clocks(cfg_r.latency);
                        end
                    ST_LAT:
                        if (slot_load)
                            st_r <= ST_STREAM;
                        else if (active_edge)
                            lat_cnt_r <= lat_cnt_r - 3'h1;
                    ST_STREAM:
                        if (slot_load && look_r.kind == SLOT_END)
                            st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Lookahead pair lets the early wait flag see the coming slot
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cur_r  <= '{kind: SLOT_END, addr: '0};
            look_r <= '{kind: SLOT_END, addr: '0};
        end
        else if (clk_en && gen_step && !sel_rise)
        begin
            look_r <= gen_slot;
            if (slot_load)
                cur_r <= look_r;
        end
    end

    // Hold phase: second active edge of a two-clock word
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            phase_r <= 1'b0;
        else if (clk_en)
        begin
            if (slot_load || st_r != ST_STREAM)
                phase_r <= 1'b0;
            else if (active_edge)
                phase_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Asynchronous mode holds wait asserted; idle sync mode releases it
    always_comb
    begin
        if (cfg_r.read_mode)
            wait_int = 1'b1;
        else if (st_r != ST_STREAM)
            wait_int = 1'b0;
        else if (cfg_r.wait_timing)
            wait_int = (look_r.kind == SLOT_WAIT);
        else
            wait_int = (cur_r.kind == SLOT_WAIT);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wait_pin_r   <= 1'b1;
            data_valid_r <= 1'b0;
            burst_addr_r <= '0;
            dq_out_r     <= '0;
            dq_oe_r      <= 1'b0;
        end
        else if (clk_en)
        begin
            wait_pin_r   <= cfg_r.wait_pol ? wait_int : !wait_int;
            data_valid_r <= (st_r == ST_STREAM) &&
                            (cur_r.kind == SLOT_DATA);
            burst_addr_r <= cur_r.addr;
            dq_out_r     <= array_rdata;
            dq_oe_r      <= (st_r == ST_STREAM);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking brc_cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_sync_latch;
        clk_en && sel_rise && !cfg_r.read_mode && !chip_en_n;
    endsequence

    sequence s_start_edge;
        clk_en && st_r == ST_ARMED && active_edge && !chip_en_n &&
        !sel_rise;
    endsequence

    arm_on_latch_a: assert property (
        s_sync_latch |=> st_r == ST_ARMED)
        else $error("burst not armed after select fell");

    async_stays_idle_a: assert property (
        (clk_en && cfg_r.read_mode && st_r == ST_IDLE) |=> st_r == ST_IDLE)
        else $error("burst started in asynchronous mode");

    latency_load_a: assert property (
        s_start_edge |=> (st_r == ST_LAT &&
                          lat_cnt_r == lat_clocks($past(cfg_r.latency))))
        else $error("latency count not loaded on start edge");

    aligned_no_wait_a: assert property (
        (st_r != ST_IDLE && start_r[1:0] == 2'h0) |-> wait_left_r == 2'h0)
        else $error("wait state on aligned start");

    wait_length_a: assert property (
        $rose(waited_r) |-> wait_left_r == start_r[1:0])
        else $error("wait count differs from start offset");

    wait_once_a: assert property (
        (clk_en && st_r == ST_STREAM && waited_r && !sel_rise && !chip_en_n)
        |=> waited_r)
        else $error("boundary wait rearmed within a burst");

    hold_phase_a: assert property (
        (clk_en && slot_load && cfg_r.data_hold && st_r == ST_STREAM)
        |=> !phase_r)
        else $error("two-clock word did not restart its hold");

    wait_invalid_a: assert property (
        (clk_en && st_r == ST_STREAM && cur_r.kind == SLOT_WAIT)
        |=> !data_valid_r)
        else $error("data marked valid during a wait slot");

    abort_idle_a: assert property (
        (clk_en && chip_en_n) |=> st_r == ST_IDLE)
        else $error("burst survived chip select release");

    wait_low_pol_a: assert property (
        (clk_en && !cfg_r.wait_pol && cfg_r.read_mode) |=> !wait_pin_r)
        else $error("active-low wait not driven low");

endmodule : brc_sequencer
`default_nettype wire

// file: tb/brc_host_model.sv
// Host controller model: burst clock and array data for the sequencer
`timescale 1ns/10ps
`default_nettype none
module brc_host_model
    import brc_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  run,
    input  wire logic                  edge_sel,
    input  wire logic [BRC_ADDR_W-1:0] burst_addr,
    output logic                       flash_clk,
    output logic      [BRC_DATA_W-1:0] array_rdata,
    output int                         edge_cnt
);
    logic [1:0] div_r;

    // ------------------------------------------------------------
    // Burst clock
    // ------------------------------------------------------------
    // Clock stands at its idle level between bursts, so the first
    // toggle of a burst is always an active edge
    initial
    begin
        flash_clk = 1'b0;
        div_r     = 2'h0;
        edge_cnt  = 0;
    end

    always @(negedge sys_clk)
    begin
        if (!run)
        begin
            flash_clk <= ~edge_sel;
            div_r     <= 2'h0;
            edge_cnt  <= 0;
        end
        else
        begin
            div_r <= div_r + 2'h1;
            if (div_r[0])
            begin
                flash_clk <= ~flash_clk;
                if (flash_clk != edge_sel)
                    edge_cnt <= edge_cnt + 1;  // Active edges seen
            end
        end
    end

    // Released data is inverted so a stale word never looks right
    assign array_rdata = run ? (burst_addr[15:0] ^ 16'hC3A5)
                             : ~(burst_addr[15:0] ^ 16'hC3A5);
endmodule : brc_host_model
`default_nettype wire

// file: tb/brc_sequencer_tb.sv
// Self-checking testbench of the burst read sequencer
`timescale 1ns/10ps
`default_nettype none
module brc_sequencer_tb
    import brc_pkg::*;
;
    typedef logic [BRC_ADDR_W-1:0] brc_tb_addr_t;
    logic                  sys_clk, reset, clk_en, cfg_wr_en, run;
    logic                  latch_n, chip_en_n, flash_clk, dq_oe;
    logic                  data_valid, wait_pin, pv, dq_chk, first;
    logic                  cont_mode;
    logic [15:0]           cfg_wdata, cfg_rdata, exp_cfg;
    logic [BRC_DATA_W-1:0] array_rdata, dq_out;
    logic [31:0]           rnd;
    brc_tb_addr_t          addr_in, burst_addr, pa, dq_a;
    brc_tb_addr_t          exp_q[$];
    brc_cfg_t              cur;
    int                    edge_cnt, run_len, wait_cnt, i;
    int                    mismatches, total_checks;

    // Every length, order, edge and latency; continuous only with
    // sequential order already chosen
    // Last entry is asynchronous with an active-low wait pin
    localparam logic [15:0] CFG_TBL [11] = '{16'hBFCF, 16'h10C9,
        16'h5C81, 16'h2641, 16'h2D42, 16'h1483, 16'h1DCB, 16'h268A,
        16'h3CFF, 16'h2CC9, 16'h83CA};
    localparam brc_tb_addr_t START_TBL [11] = '{21'h5, 21'hD, 21'h7,
        21'h1, 21'h3, 21'h1, 21'hF, 21'hC, 21'h3FFF5, 21'hE, 21'h2};

    always #4 sys_clk = ~sys_clk;

    brc_sequencer brc_sequencer_i (.sys_clk, .reset, .clk_en,
        .cfg_wr_en, .cfg_wdata, .cfg_rdata, .flash_clk, .latch_n,
        .chip_en_n, .addr_in, .array_rdata, .burst_addr, .dq_out,
        .dq_oe, .data_valid, .wait_pin);
    brc_host_model brc_host_model_i (.sys_clk, .run,
        .edge_sel(cur.edge_sel), .burst_addr, .flash_clk, .array_rdata,
        .edge_cnt);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr

    function automatic int words(input brc_cfg_t c);
        words = (c.burst_length inside {3'h1, 3'h2, 3'h3}) ?
                (2 << c.burst_length) : 0;
    endfunction : words

    function automatic int lat(input brc_cfg_t c);
        lat = (c.latency inside {[3'h2:3'h5]}) ? int'(c.latency) : 5;
    endfunction : lat

    function automatic brc_tb_addr_t exp_addr(input brc_cfg_t c,
                                              input brc_tb_addr_t s,
                                              input int k);
        brc_tb_addr_t m;
        brc_tb_addr_t kk;
        m = brc_tb_addr_t'(words(c) - 1);
        kk = brc_tb_addr_t'(k);
        if (words(c) == 0 || (c.burst_order && c.wrap_sel))
            exp_addr = s + kk;
        else if (c.burst_order)
            exp_addr = (s & ~m) | ((s + kk) & m);
        else
            exp_addr = (s & ~m) | ((s ^ kk) & m);
    endfunction : exp_addr

    // Boundary stall is only owed when words remain past word 15
    function automatic int waits(input brc_cfg_t c, input brc_tb_addr_t s);
        int n;
        n = words(c);
        waits = 0;
        if (!c.read_mode && c.burst_order && (n == 0 || c.wrap_sel)
            && (n == 0 || int'(s[3:0]) + n > 16))
            waits = int'(s[1:0]);
    endfunction : waits

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Driver: configure, note expected words, then latch
    // ------------------------------------------------------------
    task automatic burst(input logic [15:0] w, input brc_tb_addr_t s0);
        brc_tb_addr_t s;
        int           k;
        rnd = lfsr(rnd);
        s = (s0 < 16) ? {rnd[20:4], s0[3:0]} : s0;
        // Early update lets the burst clock settle at its new idle level
        cur = w & ~CFG_RSVD_MASK;
        cfg_wr_en <= 1'b1;
        cfg_wdata <= w;
        @(negedge sys_clk);
        cfg_wr_en <= 1'b0;
        @(negedge sys_clk);
        check("cfg_rdata", cfg_rdata, w & ~CFG_RSVD_MASK);
        cont_mode = (words(cur) == 0) && !cur.read_mode;
        for (k = 0; k < (cur.read_mode ? 0 : cont_mode ? 40 : words(cur)); k++)
            exp_q.push_back(exp_addr(cur, s, k));
        wait_cnt = 0;
        first = 1'b1;
        latch_n <= 1'b0;
        chip_en_n <= 1'b0;
        addr_in <= s;
        run <= 1'b1;
        @(negedge sys_clk);
        latch_n <= 1'b1;
        addr_in <= ~s;
        for (k = 0; k < 3000 && exp_q.size() != 0; k++)
            @(negedge sys_clk);
        if (exp_q.size() != 0)
        begin
            mismatches++;
            wrap_up();
        end
        // Continuous: release before the next word, after the last data
        repeat (cont_mode ? 1 : 40) @(negedge sys_clk);
        chip_en_n <= 1'b1;
        run <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check("valid at end", data_valid, 0);
        check("wait count", wait_cnt, 4 * waits(cur, s));
        check("idle wait", wait_pin, cur.read_mode ^ !cur.wait_pol);
    endtask : burst

    // Result side: each fresh data slot takes the oldest note
    always @(negedge sys_clk)
    begin
        if (dq_chk)
            check("dq_out", dq_out, dq_a[15:0] ^ 16'hC3A5);
        dq_chk = 1'b0;
        if (data_valid === 1'b1 && pv && burst_addr === pa)
            run_len++;
        else if (data_valid === 1'b1)
        begin
            if (pv)
                check("hold", run_len, 4 * (1 + cur.data_hold));
            run_len = 1;
            dq_chk = 1'b1;
            dq_a = burst_addr;
            if (first)
                check("latency", edge_cnt, lat(cur) + 1);
            first = 1'b0;
            if (exp_q.size() != 0)
                check("burst_addr", burst_addr, exp_q.pop_front());
            else if (!cont_mode)
                check("extra word", 1, 0);
        end
        if (dq_oe === 1'b1 && wait_pin === cur.wait_pol)
        begin
            wait_cnt++;
            if (!cur.wait_timing)
                check("valid in wait", data_valid, 0);
        end
        pv = (data_valid === 1'b1);
        pa = burst_addr;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        reset = 1'b1;
        clk_en = 1'b1;
        cfg_wr_en = 1'b0;
        cfg_wdata = 16'h0000;
        latch_n = 1'b1;
        chip_en_n = 1'b1;
        addr_in = '0;
        run = 1'b0;
        {pv, dq_chk, first, cont_mode} = 4'h0;
        cur = CFG_RESET;
        rnd = 32'h00009B7C;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(negedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        check("cfg reset", cfg_rdata, CFG_RESET);
        check("wait reset", wait_pin, 1);
        check("valid reset", data_valid, 0);
        check("oe reset", dq_oe, 0);
        // Writes with the clock enable low must leave the register alone
        exp_cfg = CFG_RESET;
        for (i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            clk_en <= i[0];
            cfg_wr_en <= 1'b1;
            cfg_wdata <= rnd[15:0];
            @(negedge sys_clk);
            cfg_wr_en <= 1'b0;
            clk_en <= 1'b1;
            @(negedge sys_clk);
            if (i[0])
                exp_cfg = rnd[15:0] & ~CFG_RSVD_MASK;
            check("cfg write", cfg_rdata, exp_cfg);
        end
        for (i = 0; i < 11; i++)
            burst(CFG_TBL[i], START_TBL[i]);
        wrap_up();
    end
endmodule : brc_sequencer_tb
`default_nettype wire
